// ### verilog/ccr_defs.svh
// Offsets, field positions, reset values and timing counts of the chroma control registers
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CCR_IDX_GAIN        10'h00F
`define CCR_IDX_OFFBW       10'h010
`define CCR_IDX_MODE        10'h011
`define CCR_IDX_SEARCH      10'h020
`define CCR_IDX_STATUS      10'h021

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCR_GAIN_MAN_BIT    7
`define CCR_GAIN_VAL_MSB    6
`define CCR_OFFU_MSB        7
`define CCR_OFFU_LSB        6
`define CCR_OFFV_MSB        5
`define CCR_OFFV_LSB        4
`define CCR_CHROMA_BANDWIDTH_SEL_BIT        3
`define CCR_LCBW_MSB        2
`define CCR_COLOUR_FORCE_ON_BIT        7
`define CCR_RT_OUT1_INVERT_BIT        6
`define CCR_HDEL_MSB        5
`define CCR_HDEL_LSB        4
`define CCR_RT_OUT0_INVERT_BIT        3
`define CCR_YDEL_MSB        2
`define CCR_AUTO_MSB        1
`define CCR_PREF_MSB        4
`define CCR_PREF_LSB        2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCR_RST_GAIN        8'h24
`define CCR_RST_OFFBW       8'h00
`define CCR_RST_MODE        8'h00
`define CCR_RST_SEARCH      8'h00

// ----------------------------------------------------------------
// Gain map, in units of 1/64
// ----------------------------------------------------------------
`define CCR_GAIN_CODE_NOM   7'h24
`define CCR_GAIN_CODE_MAX   7'h7F
`define CCR_GAIN_MIN        9'h020
`define CCR_GAIN_NOM        9'h048
`define CCR_GAIN_MAX        9'h1E0

// ----------------------------------------------------------------
// Standard codes and timing counts
// ----------------------------------------------------------------
`define CCR_STD_PAL         3'h0
`define CCR_STD_PAL_NTSCJ   3'h4
`define CCR_STD_SECAM       3'h5
`define CCR_STEP_LLC        2
`define CCR_DWELL_CYCLES    16'h0400
`define CCR_LUMA_BIAS       3'h4

`endif

// ### verilog/ccr_pkg.sv
// Types shared by the chroma control register bank
`default_nettype none
package ccr_pkg;

	// Standard search machine states
	typedef enum logic [1:0] {
		CCR_SRCH_OFF  = 2'b00,
		CCR_SRCH_PREF = 2'b01,
		CCR_SRCH_ALT  = 2'b10,
		CCR_SRCH_LOCK = 2'b11
	} ccr_search_state_t;

	// Bus response codes
	typedef enum logic [1:0] {
		CCR_RESP_OKAY   = 2'b00,
		CCR_RESP_SLVERR = 2'b10
	} ccr_resp_t;

endpackage
`default_nettype wire

// ### verilog/ccr_delay_if.sv
// Connection between the register bank and its step delay lines
`default_nettype none
interface ccr_delay_if #(
	parameter int W  = 1,
	parameter int SW = 2
);
	logic [W-1:0]  data_in;
	logic [SW-1:0] steps;
	logic [W-1:0]  data_out;

	modport ctl (output data_in, output steps, input data_out);
	modport dly (input data_in, input steps, output data_out);
endinterface
`default_nettype wire

// ### verilog/ccr_step_delay.sv
// Delay line whose length is set in steps of two line-locked clock periods
`default_nettype none
`include "ccr_defs.svh"
module ccr_step_delay
	import ccr_pkg::*;
#(
	parameter int W  = 1,
	parameter int SW = 2
) (
	// Clock, reset, enable
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	// Data and step count
	ccr_delay_if.dly  dl
);
	localparam int DEPTH = ((1 << SW) - 1) * `CCR_STEP_LLC;

	logic [W-1:0] pipe      [DEPTH];
	logic [W-1:0] next_pipe [DEPTH];
	logic [W-1:0] out_q;
	logic [W-1:0] next_out;
	int           tap;

	// Shift chain and tap selection
	always_comb begin
		tap = int'(dl.steps) * `CCR_STEP_LLC;
		next_pipe[0] = dl.data_in;
		for (int i = 1; i < DEPTH; i++) begin
			next_pipe[i] = pipe[i-1];
		end
		if (tap == 0) begin
			next_out = dl.data_in;
		end else begin
			next_out = pipe[tap-1];
		end
	end

	// Register the chain
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe[i] <= '0;
			end
			out_q <= '0;
		end else if (ce_in) begin
			pipe  <= next_pipe;
			out_q <= next_out;
		end
	end

	assign dl.data_out = out_q;
endmodule // ccr_step_delay
`default_nettype wire

// ### verilog/ccr_top.sv
// Chroma control register bank with AXI4-Lite access and the logic it steers
//
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
`include "ccr_defs.svh"

module ccr_top
	import ccr_pkg::*;
#(
	parameter int        AW     = 12,
	parameter int        LUMA_W = 8,
	parameter int        CW     = 8,
	parameter logic [15:0] DWELL = `CCR_DWELL_CYCLES
) (
	// Clock, reset, enable
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	// AXI4-Lite write channels
	input  wire logic [AW-1:0]     s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	// AXI4-Lite read channels
	input  wire logic [AW-1:0]     s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	// Video datapath inputs
	input  wire logic              horizontal_sync_pulse_in,
	input  wire logic [LUMA_W-1:0] luma_in,
	input  wire logic [CW-1:0]     blue_diff_in,
	input  wire logic [CW-1:0]     red_diff_in,
	input  wire logic [8:0]        agc_gain_in,
	input  wire logic              colour_detected_in,
	input  wire logic              std_match_in,
	input  wire logic              rt_src0_in,
	input  wire logic              rt_src1_in,
	// Video datapath controls and outputs
	output logic                   horizontal_sync_pulse_out,
	output logic [LUMA_W-1:0]      luma_out,
	output logic [CW+1:0]          blue_diff_out,
	output logic [CW+1:0]          red_diff_out,
	output logic [8:0]             chroma_gain_out,
	output logic                   chroma_bandwidth_sel_out,
	output logic [2:0]             chroma_bw_index_out,
	output logic [2:0]             luma_bw_index_out,
	output logic                   colour_enable_out,
	output logic                   rt_status_out0,
	output logic                   rt_status_out1,
	// Standard detection
	output logic [2:0]             trial_std_out,
	output logic [2:0]             detected_std_out,
	output logic                   std_locked_out,
	output logic                   detect_active_out,
	output logic                   filter_preset_out
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Register index of a byte address, with a hit flag
	function automatic logic [10:0] reg_decode(input logic [AW-1:0] addr);
		logic [9:0] idx;
		logic       hit;
		idx = 10'(addr[AW-1:2]);
		hit = (addr[1:0] == 2'b00) && ((idx == `CCR_IDX_GAIN) || (idx == `CCR_IDX_OFFBW) ||
			(idx == `CCR_IDX_MODE) || (idx == `CCR_IDX_SEARCH) || (idx == `CCR_IDX_STATUS));
		return {hit, idx};
	endfunction

	// Manual gain code to gain in 1/64 units, two linear pieces through the nominal point
	function automatic logic [8:0] gain_map(input logic [6:0] code);
		logic [15:0] prod;
		logic [8:0]  g;
		prod = '0;
		if (code <= `CCR_GAIN_CODE_NOM) begin
			prod = 16'(code) * 16'(`CCR_GAIN_NOM - `CCR_GAIN_MIN);
			g = `CCR_GAIN_MIN + 9'(prod / 16'(`CCR_GAIN_CODE_NOM));
		end else begin
			prod = 16'(code - `CCR_GAIN_CODE_NOM) * 16'(`CCR_GAIN_MAX - `CCR_GAIN_NOM);
			g = `CCR_GAIN_NOM + 9'(prod / 16'(`CCR_GAIN_CODE_MAX - `CCR_GAIN_CODE_NOM));
		end
		return g;
	endfunction

	// ----------------------------------------------------------------
	// Register storage and bus slave state
	// ----------------------------------------------------------------
	logic [7:0]    gain_reg, next_gain_reg;
	logic [7:0]    offbw_reg, next_offbw_reg;
	logic [7:0]    mode_reg, next_mode_reg;
	logic [7:0]    search_reg, next_search_reg;
	logic          aw_held, next_aw_held;
	logic          w_held, next_w_held;
	logic [AW-1:0] aw_addr, next_aw_addr;
	logic [7:0]    w_byte, next_w_byte;
	logic          w_lane0, next_w_lane0;
	logic          bvalid, next_bvalid;
	logic [1:0]    bresp, next_bresp;
	logic          rvalid, next_rvalid;
	logic [31:0]   rdata, next_rdata;
	logic [1:0]    rresp, next_rresp;
	logic [10:0]   wr_dec, rd_dec;
	logic [7:0]    status_byte;

	// Ready terms; held low while the enable is low
	assign s_axi_awready_out = ce_in && !aw_held && !bvalid;
	assign s_axi_wready_out  = ce_in && !w_held && !bvalid;
	assign s_axi_arready_out = ce_in && !rvalid;

	assign wr_dec = reg_decode(aw_addr);
	assign rd_dec = reg_decode(s_axi_araddr_in);

	// Write path: catch address and data in either order, answer once both are in
	always_comb begin
		next_aw_held    = aw_held;
		next_w_held     = w_held;
		next_aw_addr    = aw_addr;
		next_w_byte     = w_byte;
		next_w_lane0    = w_lane0;
		next_bvalid     = bvalid;
		next_bresp      = bresp;
		next_gain_reg   = gain_reg;
		next_offbw_reg  = offbw_reg;
		next_mode_reg   = mode_reg;
		next_search_reg = search_reg;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_w_held  = 1'b1;
			next_w_byte  = s_axi_wdata_in[7:0];
			next_w_lane0 = s_axi_wstrb_in[0];
		end
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_dec[10] ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
			if (wr_dec[10] && w_lane0) begin
				case (wr_dec[9:0])
					`CCR_IDX_GAIN:   next_gain_reg   = w_byte;
					`CCR_IDX_OFFBW:  next_offbw_reg  = w_byte;
					`CCR_IDX_MODE:   next_mode_reg   = w_byte;
					`CCR_IDX_SEARCH: next_search_reg = {3'h0, w_byte[`CCR_PREF_MSB:0]};
					default:         next_gain_reg   = gain_reg;
				endcase
			end
		end
		if (bvalid && s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
	end

	// Read path: one read under way at a time
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			next_rvalid = 1'b1;
			next_rresp  = rd_dec[10] ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
			case (rd_dec[10] ? rd_dec[9:0] : 10'h000)
				`CCR_IDX_GAIN:   next_rdata = {24'h0000_00, gain_reg};
				`CCR_IDX_OFFBW:  next_rdata = {24'h0000_00, offbw_reg};
				`CCR_IDX_MODE:   next_rdata = {24'h0000_00, mode_reg};
				`CCR_IDX_SEARCH: next_rdata = {24'h0000_00, search_reg};
				`CCR_IDX_STATUS: next_rdata = {24'h0000_00, status_byte};
				default:         next_rdata = 32'h0000_0000;
			endcase
		end else if (rvalid && s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
	end

	// Register the bus slave and the register file
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			gain_reg   <= `CCR_RST_GAIN;
			offbw_reg  <= `CCR_RST_OFFBW;
			mode_reg   <= `CCR_RST_MODE;
			search_reg <= `CCR_RST_SEARCH;
			aw_held    <= 1'b0;
			w_held     <= 1'b0;
			aw_addr    <= '0;
			w_byte     <= 8'h00;
			w_lane0    <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= 2'h0;
			rvalid     <= 1'b0;
			rdata      <= 32'h0000_0000;
			rresp      <= 2'h0;
		end else if (ce_in) begin
			gain_reg   <= next_gain_reg;
			offbw_reg  <= next_offbw_reg;
			mode_reg   <= next_mode_reg;
			search_reg <= next_search_reg;
			aw_held    <= next_aw_held;
			w_held     <= next_w_held;
			aw_addr    <= next_aw_addr;
			w_byte     <= next_w_byte;
			w_lane0    <= next_w_lane0;
			bvalid     <= next_bvalid;
			bresp      <= next_bresp;
			rvalid     <= next_rvalid;
			rdata      <= next_rdata;
			rresp      <= next_rresp;
		end
	end

	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out  = bresp;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out  = rdata;
	assign s_axi_rresp_out  = rresp;

	// ----------------------------------------------------------------
	// Standard search machine
	// ----------------------------------------------------------------
	ccr_search_state_t srch, next_srch;
	logic [15:0]       dwell, next_dwell;
	logic [1:0]        alt_idx, next_alt_idx;
	logic [2:0]        trial, next_trial;
	logic [2:0]        found, next_found;
	logic              auto_on;
	logic [2:0]        pref_std;
	logic [2:0]        alt_std;

	assign auto_on  = |search_reg[`CCR_AUTO_MSB:0];
	assign pref_std = search_reg[`CCR_PREF_MSB:`CCR_PREF_LSB];

	// Alternative standards visited between preferred trials
	always_comb begin
		case (alt_idx)
			2'h0:    alt_std = `CCR_STD_PAL;
			2'h1:    alt_std = `CCR_STD_PAL_NTSCJ;
			default: alt_std = `CCR_STD_SECAM;
		endcase
	end

	// preferred first: every failed alternative returns to the preferred trial
	always_comb begin
		next_srch    = srch;
		next_dwell   = dwell;
		next_alt_idx = alt_idx;
		next_trial   = trial;
		next_found   = found;
		case (srch)
			CCR_SRCH_OFF: begin
				if (auto_on) begin
					next_srch  = CCR_SRCH_PREF;
					next_trial = pref_std;
					next_dwell = 16'h0000;
				end
			end
			CCR_SRCH_PREF, CCR_SRCH_ALT: begin
				if (std_match_in) begin
					next_srch  = CCR_SRCH_LOCK;
					next_found = trial;
				end else if (dwell == DWELL - 16'h0001) begin
					next_dwell = 16'h0000;
					if (srch == CCR_SRCH_PREF) begin
						next_srch  = CCR_SRCH_ALT;
						next_trial = alt_std;
					end else begin
						next_srch    = CCR_SRCH_PREF;
						next_trial   = pref_std;
						next_alt_idx = (alt_idx == 2'h2) ? 2'h0 : alt_idx + 2'h1;
					end
				end else begin
					next_dwell = dwell + 16'h0001;
				end
			end
			CCR_SRCH_LOCK: begin
				if (!std_match_in) begin
					next_srch  = CCR_SRCH_PREF;
					next_trial = pref_std;
					next_dwell = 16'h0000;
				end
			end
			default: next_srch = CCR_SRCH_OFF;
		endcase
		// preferred trial follows a new choice at once
		if (next_srch == CCR_SRCH_PREF) begin
			next_trial = pref_std;
		end
		if (!auto_on) begin
			next_srch  = CCR_SRCH_OFF;
			next_trial = pref_std;
		end
	end

	// Register the search machine
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			srch    <= CCR_SRCH_OFF;
			dwell   <= 16'h0000;
			alt_idx <= 2'h0;
			trial   <= 3'h0;
			found   <= 3'h0;
		end else if (ce_in) begin
			srch    <= next_srch;
			dwell   <= next_dwell;
			alt_idx <= next_alt_idx;
			trial   <= next_trial;
			found   <= next_found;
		end
	end

	// ----------------------------------------------------------------
	// Control outputs steered by the registers
	// ----------------------------------------------------------------
	logic [CW+1:0] next_blue, next_red, blue_q, red_q;
	logic [8:0]    next_gain, gain_q;
	logic          next_colour, colour_q, next_rt0, rt0_q, next_rt1, rt1_q, next_preset, preset_q;

	// Gain, offsets, colour killer, status polarity
	always_comb begin
		if (gain_reg[`CCR_GAIN_MAN_BIT]) begin
			next_gain = gain_map(gain_reg[`CCR_GAIN_VAL_MSB:0]);
		end else begin
			next_gain = agc_gain_in;
		end
		next_blue = {blue_diff_in, 2'b00} + {{CW{1'b0}}, offbw_reg[`CCR_OFFU_MSB:`CCR_OFFU_LSB]};
		next_red  = {red_diff_in, 2'b00} + {{CW{1'b0}}, offbw_reg[`CCR_OFFV_MSB:`CCR_OFFV_LSB]};
		next_colour = mode_reg[`CCR_COLOUR_FORCE_ON_BIT] | colour_detected_in;
		next_rt0 = rt_src0_in ^ mode_reg[`CCR_RT_OUT0_INVERT_BIT];
		next_rt1 = rt_src1_in ^ mode_reg[`CCR_RT_OUT1_INVERT_BIT];
		next_preset = auto_on && (search_reg[`CCR_AUTO_MSB:0] != 2'b11);
	end

	// Register the control outputs
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			gain_q   <= 9'h000;
			blue_q   <= '0;
			red_q    <= '0;
			colour_q <= 1'b0;
			rt0_q    <= 1'b0;
			rt1_q    <= 1'b0;
			preset_q <= 1'b0;
		end else if (ce_in) begin
			gain_q   <= next_gain;
			blue_q   <= next_blue;
			red_q    <= next_red;
			colour_q <= next_colour;
			rt0_q    <= next_rt0;
			rt1_q    <= next_rt1;
			preset_q <= next_preset;
		end
	end

	assign chroma_gain_out   = gain_q;
	assign blue_diff_out     = blue_q;
	assign red_diff_out      = red_q;
	assign colour_enable_out = colour_q;
	assign rt_status_out0    = rt0_q;
	assign rt_status_out1    = rt1_q;
	assign filter_preset_out = preset_q;
	assign chroma_bandwidth_sel_out = offbw_reg[`CCR_CHROMA_BANDWIDTH_SEL_BIT];
	assign chroma_bw_index_out = offbw_reg[`CCR_LCBW_MSB:0];
	assign luma_bw_index_out   = ~offbw_reg[`CCR_LCBW_MSB:0];
	assign trial_std_out       = trial;
	assign detected_std_out    = found;
	assign std_locked_out      = (srch == CCR_SRCH_LOCK);
	assign detect_active_out   = (srch != CCR_SRCH_OFF);

	// Status byte seen by software
	assign status_byte = {1'b0, preset_q, colour_q, (srch != CCR_SRCH_OFF), (srch == CCR_SRCH_LOCK), found};

	// ----------------------------------------------------------------
	// Sync and luma delay lines
	// ----------------------------------------------------------------
	ccr_delay_if #(.W(1), .SW(2))      hs_if ();
	ccr_delay_if #(.W(LUMA_W), .SW(3)) luma_if ();

	assign hs_if.data_in = horizontal_sync_pulse_in;
	assign hs_if.steps   = mode_reg[`CCR_HDEL_MSB:`CCR_HDEL_LSB];
	// signed luma delay, biased so -4 maps to the shortest line
	assign luma_if.data_in = luma_in;
	assign luma_if.steps   = mode_reg[`CCR_YDEL_MSB:0] ^ `CCR_LUMA_BIAS;

	ccr_step_delay #(.W(1), .SW(2)) u_hs_delay (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.dl       (hs_if.dly)
	);

	ccr_step_delay #(.W(LUMA_W), .SW(3)) u_luma_delay (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.dl       (luma_if.dly)
	);

	assign horizontal_sync_pulse_out = hs_if.data_out;
	assign luma_out                  = luma_if.data_out;

endmodule // ccr_top
`default_nettype wire

// ### dv/ccr_top_monitor.sv
// Port assertions for the chroma control register bank
`default_nettype none
module ccr_top_monitor #(
	parameter int CW = 8
) (
	// Clock and control
	input wire logic          clock_in,
	input wire logic          rst_in,
	input wire logic          ce_in,
	input wire logic          s_axi_bvalid_out,
	// Datapath
	input wire logic [CW-1:0] blue_diff_in,
	input wire logic [CW-1:0] red_diff_in,
	input wire logic [CW+1:0] blue_diff_out,
	input wire logic [CW+1:0] red_diff_out,
	input wire logic          colour_detected_in,
	input wire logic          colour_enable_out,
	input wire logic          rt_src0_in,
	input wire logic          rt_src1_in,
	input wire logic          rt_status_out0,
	input wire logic          rt_status_out1,
	input wire logic [2:0]    chroma_bw_index_out,
	input wire logic [2:0]    luma_bw_index_out,
	// Detection
	input wire logic          std_match_in,
	input wire logic          std_locked_out,
	input wire logic          detect_active_out,
	input wire logic          filter_preset_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic live;
	// Previous edge was enabled and out of reset
	always_ff @(posedge clock_in) live <= ce_in && !rst_in;
	AST_BLUE_OFS: assert property (live |-> blue_diff_out[CW+1:2] == $past(blue_diff_in))
		else $error("blue offset output lost its integer part");
	AST_RED_OFS: assert property (live |-> red_diff_out[CW+1:2] == $past(red_diff_in))
		else $error("red offset output lost its integer part");
	AST_BW_TRADE: assert property (luma_bw_index_out == ~chroma_bw_index_out)
		else $error("bandwidth indices not complementary");
	AST_COLOUR: assert property (ce_in && colour_detected_in |=> colour_enable_out)
		else $error("colour dropped while detected");
	AST_RT1_POL: assert property (live && ce_in && $changed(rt_src1_in) && !$rose(s_axi_bvalid_out) |=> $changed(rt_status_out1))
		else $error("second status output missed a source change");
	AST_RT0_POL: assert property (live && ce_in && $changed(rt_src0_in) && !$rose(s_axi_bvalid_out) |=> $changed(rt_status_out0))
		else $error("first status output missed a source change");
	AST_PRESET_OFF: assert property (!detect_active_out [*2] |-> !filter_preset_out)
		else $error("filter preset while detection is off");
	AST_LOCK_AUTO: assert property (std_locked_out |-> detect_active_out && (!live || $past(std_match_in)))
		else $error("locked while detection is off");
	// Main scenarios reached
	cover property (std_locked_out);
	cover property ($rose(filter_preset_out));
	cover property (colour_enable_out && !colour_detected_in);
endmodule // ccr_top_monitor
bind ccr_top ccr_top_monitor #(.CW(CW)) i_ccr_top_monitor (.*);
`default_nettype wire

// ### dv/ccr_top_test.sv
// Self-checking testbench of the chroma control register bank
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module ccr_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 0, rst_in = 1, ce_in = 1;
	logic [11:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
	logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic horizontal_sync_pulse_in = 0, colour_detected_in = 0, std_match_in = 0, rt_src0_in = 0, rt_src1_in = 0;
	logic [7:0] luma_in = 0, blue_diff_in = 0, red_diff_in = 0, luma_out;
	logic [8:0] agc_gain_in = 0, chroma_gain_out;
	logic [9:0] blue_diff_out, red_diff_out;
	logic horizontal_sync_pulse_out, chroma_bandwidth_sel_out, colour_enable_out, rt_status_out0, rt_status_out1;
	logic [2:0] chroma_bw_index_out, luma_bw_index_out, trial_std_out, detected_std_out;
	logic std_locked_out, detect_active_out, filter_preset_out;
	logic [7:0] sv [5] = '{8'h16, 8'h12, 8'h03, 8'h01, 8'h00};
	int fails = 0, checked = 0, seed = 96039, cyc = 0;
	ccr_top #(.DWELL(16'h0008)) i_ccr_top (.*);
	// Clock and hang guard
	always #10 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Bus cycles and helpers
	// ----------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] r);
		logic ta, tw, na, nw;
		ta = 0;
		tw = 0;
		@(posedge clock_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h00_0000, v};
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'b111;
		while (!(ta && tw)) begin
			@(negedge clock_in);
			na = s_axi_awready_out && !ta;
			nw = s_axi_wready_out && !tw;
			@(posedge clock_in);
			if (na) begin s_axi_awvalid_in <= 0; ta = 1; end
			if (nw) begin s_axi_wvalid_in <= 0; tw = 1; end
		end
		do @(negedge clock_in); while (!s_axi_bvalid_out);
		r = s_axi_bresp_out;
		@(posedge clock_in) s_axi_bready_in <= 0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_in);
		s_axi_araddr_in <= a;
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'b11;
		do @(negedge clock_in); while (!s_axi_arready_out);
		@(posedge clock_in) s_axi_arvalid_in <= 0;
		do @(negedge clock_in); while (!s_axi_rvalid_out);
		{d, r} = {s_axi_rdata_out, s_axi_rresp_out};
		@(posedge clock_in) s_axi_rready_in <= 0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		@(negedge clock_in);
	endtask
	function automatic logic [8:0] gain_exp(input logic [6:0] c);
		return (c <= 36) ? 9'(32 + c * 40 / 36) : 9'(72 + (c - 36) * 408 / 91);
	endfunction
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [7:0] v, lv;
		logic [1:0] r;
		int hd, ld;
		repeat (3) @(posedge clock_in);
		rst_in <= 0;
		rd(12'h03C, d, r); `CHK(d, 32'h0000_0024)
		rd(12'h044, d, r); `CHK(d, 32'h0000_0000)
		rd(12'h100, d, r); `CHK(r, 2'b10)
		wr(12'h03D, 8'hFF, r); `CHK(r, 2'b10)
		rd(12'h03C, d, r); `CHK(d, 32'h0000_0024)
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			if (i < 3) v[6:0] = (i == 0) ? 7'h00 : (i == 1) ? 7'h24 : 7'h7F;
			v[7] = (i < 6);
			@(posedge clock_in) agc_gain_in <= 9'($random(seed));
			wr(12'h03C, v, r);
			tick(2);
			`CHK(chroma_gain_out, v[7] ? gain_exp(v[6:0]) : agc_gain_in)
		end
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hFF : 8'($random(seed));
			@(posedge clock_in);
			blue_diff_in <= 8'($random(seed));
			red_diff_in <= 8'($random(seed));
			wr(12'h040, v, r);
			tick(2);
			`CHK(blue_diff_out, {blue_diff_in, 2'b00} + 10'(v[7:6]))
			`CHK(red_diff_out, {red_diff_in, 2'b00} + 10'(v[5:4]))
			`CHK(chroma_bandwidth_sel_out, v[3])
			`CHK({chroma_bw_index_out, luma_bw_index_out}, {v[2:0], ~v[2:0]})
			rd(12'h040, d, r); `CHK(d, {24'h00_0000, v})
		end
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			v[2:0] = 3'(i);
			v[5:4] = 2'(i + 1);
			wr(12'h044, v, r);
			@(posedge clock_in);
			{rt_src0_in, rt_src1_in, colour_detected_in} <= 3'($random(seed));
			luma_in <= 8'h00;
			tick(1);
			`CHK(rt_status_out0, rt_src0_in ^ v[3])
			`CHK(rt_status_out1, rt_src1_in ^ v[6])
			`CHK(colour_enable_out, v[7] | colour_detected_in)
			lv = 8'($random(seed)) | 8'h01;
			repeat (20) @(posedge clock_in);
			{luma_in, horizontal_sync_pulse_in} <= {lv, 1'b1};
			{hd, ld} = 0;
			for (int n = 1; n <= 20; n++) begin
				@(negedge clock_in);
				if (horizontal_sync_pulse_out === 1'b1 && hd == 0) hd = n;
				if (luma_out === lv && ld == 0) ld = n;
				@(posedge clock_in) horizontal_sync_pulse_in <= 0;
			end
			`CHK(hd, 2 + 2 * int'(v[5:4]))
			`CHK(ld, 2 + 2 * int'(v[2:0] ^ 3'b100))
		end
		for (int i = 0; i < 5; i++) begin
			wr(12'h080, sv[i], r);
			tick(1);
			`CHK(detect_active_out, |sv[i][1:0])
			`CHK(filter_preset_out, sv[i][1:0] == 2'b01 || sv[i][1:0] == 2'b10)
			if (i < 4) `CHK(trial_std_out, sv[i][4:2])
			if (i == 0) begin
				@(posedge clock_in) std_match_in <= 1;
				tick(2);
				`CHK({std_locked_out, detected_std_out}, {1'b1, sv[i][4:2]})
				rd(12'h084, d, r);
				`CHK({d[6], d[4:0]}, {3'b111, sv[i][4:2]})
				@(posedge clock_in) std_match_in <= 0;
				tick(2);
				`CHK({std_locked_out, trial_std_out}, {1'b0, sv[i][4:2]})
			end
		end
		// Enable low freezes the datapath and drops the readys
		v = blue_diff_in;
		@(posedge clock_in) {ce_in, blue_diff_in} <= {1'b0, ~v};
		tick(3);
		`CHK({s_axi_arready_out, blue_diff_out[9:2]}, {1'b0, v})
		@(posedge clock_in) ce_in <= 1'b1;
		tick(2);
		`CHK(blue_diff_out[9:2], ~v)
		stop_test();
	end
endmodule // ccr_top_test
`default_nettype wire
